// *** rtl/omsr_defines.vh ***
// constants for the optical module status and rate select block
// assumes a 25 MHz ref_clk and one byte-wide management port
`ifndef OMSR_DEFINES_VH
`define OMSR_DEFINES_VH

// register offsets (byte addresses of the management page)
`define OMSR_SOFT_CMD_OFS     8'h6E
`define OMSR_ALARM_MAIN_OFS   8'h70
`define OMSR_ALARM_RXP_OFS    8'h71
`define OMSR_WARN_MAIN_OFS    8'h74
`define OMSR_WARN_RXP_OFS     8'h75
`define OMSR_EXT_CTRL_OFS     8'h76

// soft command byte fields
`define OMSR_SC_TXDIS_STATE   7
`define OMSR_SC_SW_TXDIS      6
`define OMSR_SC_TX_RATE_PIN   5
`define OMSR_SC_RX_RATE_PIN   4
`define OMSR_SC_SW_RX_RATE    3
`define OMSR_SC_TX_FAULT      2
`define OMSR_SC_RX_LOSS       1
`define OMSR_SC_NOT_READY     0

// extended control byte field
`define OMSR_EC_SW_TX_RATE    3

// reset values of software bits
`define OMSR_SW_BIT_RST       1'h0

// monitor channel order and threshold order inside a channel
`define OMSR_CH_TEMP          0
`define OMSR_CH_VCC           1
`define OMSR_CH_BIAS          2
`define OMSR_CH_TXPWR         3
`define OMSR_CH_RXPWR         4
`define OMSR_NUM_CH           5
`define OMSR_MON_W            16
`define OMSR_THR_HI_ALARM     0
`define OMSR_THR_LO_ALARM     1
`define OMSR_THR_HI_WARN      2
`define OMSR_THR_LO_WARN      3

// soft command response time and its cycle count at 25 MHz
`define OMSR_RESP_TIME_MS     100
`define OMSR_CLK_HZ           25000000
`define OMSR_RESP_CYCLES      ((`OMSR_RESP_TIME_MS * `OMSR_CLK_HZ) / 1000)
// flags refresh four times per response window
`define OMSR_REFRESH_DIV      4

`endif

// *** rtl/omsr_top.v ***
// optical module status, alarm and warning flags, and rate select
// assumes monitors and thresholds come from logic on ref_clk; the
// disable and rate select pins arrive asynchronously from the host
//
// Local design decision: the strobed register port.
`include "omsr_defines.vh"
`default_nettype none

// Summary of operation
// (R01) receive loss level shown in status bit 1
// (R02) not-ready bit 0 low once monitors valid
// (R03) software writes act within response time
// (R04) software disable ORed with disable pin
// (R05) temperature high and low alarm flags
// (R06) supply voltage high and low alarm flags
// (R07) laser bias high and low alarm flags
// (R08) transmit power high and low alarm flags
// (R09) receive power alarm flags, rest reserved
// (R10) temperature and supply warning flags
// (R11) bias and transmit power warning flags
// (R12) receive power warning flags, rest reserved
// (R13) receive and transmit rates chosen independently
// (R14) rate select pin levels mirrored in status
// (R15) software rate bits cleared at reset
// (R16) receiver slow only when pin and bit low
// (R17) transmitter slow only when pin and bit low
// (R18) disable pin level shown in status bit 7
// (R19) transmit fault level shown in status bit 2
// (R20) flags clear when quantity back inside limits
module omsr_top #(
   parameter RESP_CYCLES = `OMSR_RESP_CYCLES // response window
) (
   input  wire         ref_clk,                  // 25 MHz clock
   input  wire         srst,                     // sync reset, high
   input  wire         clk_en,                   // freezes state when low
   input  wire [7:0]   reg_addr,                 // register byte address
   input  wire [7:0]   reg_wdata,                // write data
   input  wire         reg_wr,                   // write strobe
   input  wire         reg_rd,                   // read strobe
   output reg  [7:0]   reg_rdata,                // read data, next cycle
   input  wire         tx_disable_pin,           // async disable pin
   input  wire         receive_rate_select_pin,  // async rx rate pin
   input  wire         transmit_rate_select_pin, // async tx rate pin
   input  wire         tx_fault_in,              // transmit fault level
   input  wire         receive_loss_state,       // receive loss level
   input  wire         mon_valid,                // monitors powered, valid
   input  wire [79:0]  mon_values,               // 5 monitors, 16 bits
   input  wire [319:0] mon_thresholds,           // 5 x 4 limits, 16 bits
   output reg          tx_off,                   // transmitter off
   output reg          rx_rate_full,             // 1: rx 10G, 0: 1.25G
   output reg          tx_rate_full              // 1: tx 10G, 0: 1.25G
);

   localparam REFRESH = RESP_CYCLES / `OMSR_REFRESH_DIV;

   // pin synchronisers: three stages, change taken when 2nd and 3rd agree
   reg  [2:0] txdis_sync_q;
   reg  [2:0] rxrs_sync_q;
   reg  [2:0] txrs_sync_q;
   reg        txdis_q;
   reg        rxrs_q;
   reg        txrs_q;

   // software bits
   reg        sw_txdis_q;
   reg        sw_receive_rate_bit_q;
   reg        sw_transmit_rate_bit_q;

   // flag bytes, status
   reg  [7:0] alarm_main_q;
   reg  [1:0] alarm_rxp_q;
   reg  [7:0] warn_main_q;
   reg  [1:0] warn_rxp_q;
   reg        not_ready_q;

   // refresh timer
   reg  [31:0] refresh_cnt_q;
   wire        refresh_tick;

   // comparison results, per channel
   wire [4:0] hi_alarm;
   wire [4:0] lo_alarm;
   wire [4:0] hi_warn;
   wire [4:0] lo_warn;

   wire [7:0] soft_cmd_byte;
   wire [7:0] ext_ctrl_byte;

   // synchroniser chains and debounced levels
   always @(posedge ref_clk) begin
      if (srst) begin
         txdis_sync_q <= 3'h0;
         rxrs_sync_q  <= 3'h0;
         txrs_sync_q  <= 3'h0;
         txdis_q      <= 1'h0;
         rxrs_q       <= 1'h0;
         txrs_q       <= 1'h0;
      end else if (clk_en) begin
         txdis_sync_q <= {txdis_sync_q[1:0], tx_disable_pin};
         rxrs_sync_q  <= {rxrs_sync_q[1:0], receive_rate_select_pin};
         txrs_sync_q  <= {txrs_sync_q[1:0], transmit_rate_select_pin};
         if (txdis_sync_q[1] == txdis_sync_q[2])
            txdis_q <= txdis_sync_q[2];
         if (rxrs_sync_q[1] == rxrs_sync_q[2])
            rxrs_q <= rxrs_sync_q[2];
         if (txrs_sync_q[1] == txrs_sync_q[2])
            txrs_q <= txrs_sync_q[2];
      end
   end

   // software writable bits, cleared at reset
   always @(posedge ref_clk) begin
      if (srst) begin
         sw_txdis_q             <= `OMSR_SW_BIT_RST;
         sw_receive_rate_bit_q  <= `OMSR_SW_BIT_RST; // see (R15)
         sw_transmit_rate_bit_q <= `OMSR_SW_BIT_RST; // see (R15)
      end else if (clk_en && reg_wr) begin
         if (reg_addr == `OMSR_SOFT_CMD_OFS) begin
            sw_txdis_q            <= reg_wdata[`OMSR_SC_SW_TXDIS];
            sw_receive_rate_bit_q <= reg_wdata[`OMSR_SC_SW_RX_RATE];
         end else if (reg_addr == `OMSR_EXT_CTRL_OFS) begin
            sw_transmit_rate_bit_q <= reg_wdata[`OMSR_EC_SW_TX_RATE];
         end
      end
   end

   // control outputs follow one cycle after the software bits or the debounced pin levels change
   always @(posedge ref_clk) begin
      if (srst) begin
         tx_off       <= 1'h0;
         rx_rate_full <= 1'h0;
         tx_rate_full <= 1'h0;
      end else if (clk_en) begin
         tx_off       <= sw_txdis_q | txdis_q;              // see (R04) (R03)
         rx_rate_full <= sw_receive_rate_bit_q | rxrs_q;  // see (R16) (R13)
         tx_rate_full <= sw_transmit_rate_bit_q | txrs_q; // see (R17) (R13)
      end
   end

   // comparators per monitor channel; temperature is signed
   genvar c;
   generate
      for (c = 0; c < `OMSR_NUM_CH; c = c + 1) begin : g_ch
         wire [15:0] val;
         wire [15:0] t_ha;
         wire [15:0] t_la;
         wire [15:0] t_hw;
         wire [15:0] t_lw;
         assign val  = mon_values[c*16 +: 16];
         assign t_ha = mon_thresholds[(c*4+`OMSR_THR_HI_ALARM)*16 +: 16];
         assign t_la = mon_thresholds[(c*4+`OMSR_THR_LO_ALARM)*16 +: 16];
         assign t_hw = mon_thresholds[(c*4+`OMSR_THR_HI_WARN)*16 +: 16];
         assign t_lw = mon_thresholds[(c*4+`OMSR_THR_LO_WARN)*16 +: 16];
         if (c == `OMSR_CH_TEMP) begin : g_signed
            assign hi_alarm[c] = $signed(val) > $signed(t_ha);
            assign lo_alarm[c] = $signed(val) < $signed(t_la);
            assign hi_warn[c]  = $signed(val) > $signed(t_hw);
            assign lo_warn[c]  = $signed(val) < $signed(t_lw);
         end else begin : g_unsigned
            assign hi_alarm[c] = val > t_ha;
            assign lo_alarm[c] = val < t_la;
            assign hi_warn[c]  = val > t_hw;
            assign lo_warn[c]  = val < t_lw;
         end
      end
   endgenerate

   // refresh timer paces flag sampling well inside the response window
   assign refresh_tick = (refresh_cnt_q == 32'h0);

   always @(posedge ref_clk) begin
      if (srst) begin
         refresh_cnt_q <= 32'h0;
      end else if (clk_en) begin
         if (refresh_tick)
            refresh_cnt_q <= REFRESH - 1;
         else
            refresh_cnt_q <= refresh_cnt_q - 32'h1;
      end
   end

   // flags follow the comparators: set when out, clear when back inside
   always @(posedge ref_clk) begin
      if (srst) begin
         alarm_main_q <= 8'h00;
         alarm_rxp_q  <= 2'h0;
         warn_main_q  <= 8'h00;
         warn_rxp_q   <= 2'h0;
         not_ready_q  <= 1'h1;
      end else if (clk_en) begin
         if (!mon_valid) begin
            not_ready_q <= 1'h1;                            // see (R02)
         end else if (refresh_tick) begin
            alarm_main_q <= {hi_alarm[`OMSR_CH_TEMP],
                             lo_alarm[`OMSR_CH_TEMP],       // see (R05)
                             hi_alarm[`OMSR_CH_VCC],
                             lo_alarm[`OMSR_CH_VCC],        // see (R06)
                             hi_alarm[`OMSR_CH_BIAS],
                             lo_alarm[`OMSR_CH_BIAS],       // see (R07)
                             hi_alarm[`OMSR_CH_TXPWR],
                             lo_alarm[`OMSR_CH_TXPWR]};     // see (R08)
            alarm_rxp_q  <= {hi_alarm[`OMSR_CH_RXPWR],
                             lo_alarm[`OMSR_CH_RXPWR]};     // see (R09)
            warn_main_q  <= {hi_warn[`OMSR_CH_TEMP],
                             lo_warn[`OMSR_CH_TEMP],
                             hi_warn[`OMSR_CH_VCC],
                             lo_warn[`OMSR_CH_VCC],         // see (R10)
                             hi_warn[`OMSR_CH_BIAS],
                             lo_warn[`OMSR_CH_BIAS],
                             hi_warn[`OMSR_CH_TXPWR],
                             lo_warn[`OMSR_CH_TXPWR]};      // see (R11)
            warn_rxp_q   <= {hi_warn[`OMSR_CH_RXPWR],
                             lo_warn[`OMSR_CH_RXPWR]};      // see (R12)
            not_ready_q  <= 1'h0;                           // see (R02) (R20)
         end
      end
   end

   // status bytes assembled from pin levels and software bits
   assign soft_cmd_byte = {txdis_q,                         // see (R18)
                           sw_txdis_q,
                           txrs_q,                          // see (R14)
                           rxrs_q,                          // see (R14)
                           sw_receive_rate_bit_q,
                           tx_fault_in,                     // see (R19)
                           receive_loss_state,              // see (R01)
                           not_ready_q};                    // see (R02)
   assign ext_ctrl_byte = {4'h0, sw_transmit_rate_bit_q, 3'h0};

   // read port: data valid the cycle after the strobe, zero otherwise
   always @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         if (!reg_rd)
            reg_rdata <= 8'h00;
         else if (reg_addr == `OMSR_SOFT_CMD_OFS)
            reg_rdata <= soft_cmd_byte;
         else if (reg_addr == `OMSR_ALARM_MAIN_OFS)
            reg_rdata <= alarm_main_q;
         else if (reg_addr == `OMSR_ALARM_RXP_OFS)
            reg_rdata <= {alarm_rxp_q, 6'h00};
         else if (reg_addr == `OMSR_WARN_MAIN_OFS)
            reg_rdata <= warn_main_q;
         else if (reg_addr == `OMSR_WARN_RXP_OFS)
            reg_rdata <= {warn_rxp_q, 6'h00};
         else if (reg_addr == `OMSR_EXT_CTRL_OFS)
            reg_rdata <= ext_ctrl_byte;
         else
            reg_rdata <= 8'h00;                             // unmapped
      end
   end

endmodule // omsr_top

`default_nettype wire

// *** test/omsr_props.sv ***
// checker for the status, flag and rate select block
// assumes a bind onto omsr_top and a single ref_clk domain
`include "omsr_defines.vh"
`default_nettype none
module omsr_props (
   input wire logic       ref_clk,                  // clock
   input wire logic       srst,                     // sync reset
   input wire logic       clk_en,                   // clock enable
   input wire logic [7:0] reg_addr,                 // address
   input wire logic [7:0] reg_wdata,                // write data
   input wire logic       reg_wr,                   // write strobe
   input wire logic       reg_rd,                   // read strobe
   input wire logic [7:0] reg_rdata,                // read data
   input wire logic       tx_disable_pin,           // disable pin
   input wire logic       receive_rate_select_pin,  // rx rate pin
   input wire logic       transmit_rate_select_pin, // tx rate pin
   input wire logic       tx_fault_in,              // fault level
   input wire logic       receive_loss_state,       // loss level
   input wire logic       mon_valid,                // monitors valid
   input wire logic       tx_off,                   // transmitter off
   input wire logic       rx_rate_full,             // rx at 10G
   input wire logic       tx_rate_full              // tx at 10G
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // reads and writes of the status byte, reads of the two receive power flag bytes
   wire rd_sc = reg_rd && reg_addr == `OMSR_SOFT_CMD_OFS;
   wire wr_sc = reg_wr && reg_addr == `OMSR_SOFT_CMD_OFS;
   wire rd_rx = reg_rd && (reg_addr == `OMSR_ALARM_RXP_OFS ||
                           reg_addr == `OMSR_WARN_RXP_OFS);
   // loss and fault bits follow the raw levels at the read edge
   property p_loss; rd_sc |=> reg_rdata[1] == $past(receive_loss_state);
   endproperty
   a_loss: assert property (p_loss) else $error("loss bit");
   property p_fault; rd_sc |=> reg_rdata[2] == $past(tx_fault_in);
   endproperty
   a_fault: assert property (p_fault) else $error("fault bit");
   property p_nrdy; !mon_valid [*3] ##1 rd_sc |=> reg_rdata[0]; endproperty
   a_nrdy: assert property (p_nrdy) else $error("ready early");
   property p_pin_st; tx_disable_pin [*6] ##0 rd_sc |=> reg_rdata[7];
   endproperty
   a_pin_st: assert property (p_pin_st) else $error("pin bit");
   // software and pin disable both switch the transmitter off
   property p_swdis;
      clk_en && wr_sc && reg_wdata[6] |-> ##[1:2] tx_off;
   endproperty
   a_swdis: assert property (p_swdis) else $error("sw off");
   property p_pindis; tx_disable_pin [*6] |-> tx_off; endproperty
   a_pindis: assert property (p_pindis) else $error("pin off");
   // a high select pin forces full rate
   property p_rxpin;
      receive_rate_select_pin [*6] |-> rx_rate_full;
   endproperty
   a_rxpin: assert property (p_rxpin) else $error("rx rate");
   property p_txpin; transmit_rate_select_pin [*6] |-> tx_rate_full;
   endproperty
   a_txpin: assert property (p_txpin) else $error("tx rate");
   property p_rsvd; rd_rx |=> reg_rdata[5:0] == 6'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
   c_flag: cover property (reg_rd ##1 reg_rdata != 8'h00);
   c_off: cover property ($rose(tx_off));
   c_rate: cover property ($rose(rx_rate_full) ##1 tx_rate_full);
endmodule // omsr_props
`default_nettype wire

// *** test/omsr_host_pins.sv ***
// host side model: launches disable and rate select pin levels
// assumes the bench hands it levels; the block syncs them itself
`default_nettype none
module omsr_host_pins (
   input  wire logic       ref_clk,                 // clock
   input  wire logic [2:0] lvl,                     // dis, rx, tx
   output var  logic       tx_disable_pin,          // disable pin
   output var  logic       receive_rate_select_pin, // rx rate pin
   output var  logic       transmit_rate_select_pin // tx rate pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // pins start low and change only after an edge, all three together from lvl
   initial {tx_disable_pin, receive_rate_select_pin,
            transmit_rate_select_pin} = 3'h0;
   always @(posedge ref_clk) begin
      {tx_disable_pin, receive_rate_select_pin,
       transmit_rate_select_pin} <= lvl;
   end
endmodule // omsr_host_pins
`default_nettype wire

// *** test/optical_module_status_rate_select_tb_top.sv ***
// self-checking bench: random pins, monitors and writes against a model
// assumes omsr_top, omsr_props and omsr_host_pins are compiled
`include "omsr_defines.vh"
`default_nettype none
module optical_module_status_rate_select_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, got;
   logic tx_fault_in = 1'b0, receive_loss_state = 1'b0, mon_valid = 1'b0;
   logic [79:0] mon_values = 80'h0;
   logic [319:0] mon_thresholds = 320'h0;
   logic [2:0] lvl = 3'h0;
   logic tx_disable_pin, receive_rate_select_pin, transmit_rate_select_pin;
   logic tx_off, rx_rate_full, tx_rate_full;
   logic sw_dis = 1'b0, sw_rx = 1'b0, sw_tx = 1'b0, nrdy = 1'b1;
   logic clk_en = 1'b1;
   int error_cnt = 0, num_checks = 0;
   always #20 ref_clk = ~ref_clk;
   omsr_host_pins host (.ref_clk(ref_clk), .lvl(lvl),
      .tx_disable_pin(tx_disable_pin),
      .receive_rate_select_pin(receive_rate_select_pin),
      .transmit_rate_select_pin(transmit_rate_select_pin));
   omsr_top #(.RESP_CYCLES(32'h8)) dut (.ref_clk(ref_clk), .srst(srst),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_disable_pin(tx_disable_pin),
      .receive_rate_select_pin(receive_rate_select_pin),
      .transmit_rate_select_pin(transmit_rate_select_pin),
      .tx_fault_in(tx_fault_in), .receive_loss_state(receive_loss_state),
      .mon_valid(mon_valid), .mon_values(mon_values),
      .mon_thresholds(mon_thresholds), .tx_off(tx_off),
      .rx_rate_full(rx_rate_full), .tx_rate_full(tx_rate_full));
   // compare tasks: register bytes and output levels
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_o(input logic [2:0] g, input logic [2:0] e);
      chk({5'h0, g}, {5'h0, e});
   endtask
   // bus cycles, each entered just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge ref_clk);
   endtask
   // model: strict compares, channel 0 signed, hi and lo limit pairs
   function automatic logic [1:0] cmp(input int c, input int k);
      logic [15:0] v, h, l;
      v = mon_values[c*16+:16];
      h = mon_thresholds[(c*4+k)*16+:16];
      l = mon_thresholds[(c*4+k+1)*16+:16];
      if (c == 0) return {$signed(v) > $signed(h), $signed(v) < $signed(l)};
      return {v > h, v < l};
   endfunction
   function automatic logic [7:0] flg(input int k, input int rx);
      if (rx != 0) return {cmp(4, k), 6'h00};
      return {cmp(0, k), cmp(1, k), cmp(2, k), cmp(3, k)};
   endfunction
   // read every mapped byte plus a hole, then the outputs
   task automatic check_all();
      logic [7:0] ad [7];
      logic [7:0] ex [7];
      ad = '{8'h6E, 8'h70, 8'h71, 8'h74, 8'h75, 8'h76, 8'h72};
      ex = '{{lvl[2], sw_dis, lvl[0], lvl[1], sw_rx, tx_fault_in,
              receive_loss_state, nrdy}, flg(0, 0), flg(0, 1), flg(2, 0),
             flg(2, 1), {4'h0, sw_tx, 3'h0}, 8'h00};
      for (int i = 0; i < 7; i++) begin
         rd(ad[i], got);
         if (i == 0)
            chk(got, ex[i]);
         else if (i < 3)
            chk(got, ex[i]);
         else
            chk(got, ex[i]);
      end
      chk_o({tx_off, rx_rate_full, tx_rate_full},
            lvl | {sw_dis, sw_rx, sw_tx});
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // main sequence: reset values, random rounds, monitors lost
   initial begin
      void'($urandom(32'h3b6a));
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      check_all();
      repeat (40) begin
         lvl <= 3'($urandom);
         tx_fault_in <= 1'($urandom);
         receive_loss_state <= 1'($urandom);
         mon_valid <= 1'b1;
         for (int c = 0; c < 20; c++)
            mon_thresholds[c*16+:16] <= 16'($urandom % 4) - 16'h2;
         for (int c = 0; c < 5; c++)
            mon_values[c*16+:16] <= 16'($urandom % 4) - 16'h2;
         got = 8'($urandom);
         wr(`OMSR_SOFT_CMD_OFS, got);
         sw_dis = got[6];
         sw_rx = got[3];
         got = 8'($urandom);
         wr(`OMSR_EXT_CTRL_OFS, got);
         sw_tx = got[3];
         wr(`OMSR_ALARM_RXP_OFS, 8'($urandom));
         repeat (8) @(posedge ref_clk);
         nrdy = 1'b0;
         check_all();
      end
      // a write while the clock enable is low must not land
      clk_en <= 1'b0;
      wr(`OMSR_SOFT_CMD_OFS, {~sw_dis, 7'h7F});
      clk_en <= 1'b1;
      check_all();
      mon_valid <= 1'b0;
      repeat (4) @(posedge ref_clk);
      nrdy = 1'b1;
      check_all();
      report_and_stop();
   end
   initial begin
      #(40 * 20000);
      error_cnt++;
      report_and_stop();
   end
endmodule // optical_module_status_rate_select_tb_top
bind omsr_top omsr_props u_props (.ref_clk(ref_clk), .srst(srst),
   .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_disable_pin(tx_disable_pin),
   .receive_rate_select_pin(receive_rate_select_pin),
   .transmit_rate_select_pin(transmit_rate_select_pin),
   .tx_fault_in(tx_fault_in), .receive_loss_state(receive_loss_state),
   .mon_valid(mon_valid), .tx_off(tx_off), .rx_rate_full(rx_rate_full),
   .tx_rate_full(tx_rate_full));
`default_nettype wire
